//--- hw/floppy_host_pkg.sv
// Contract
// - Status register read with select low.
// - Data register read with select high.
// - Data register write captures bus byte.
// - Status register readable at any time.
// - Data register presents one stacked byte.
// - Bits 0-3 show drives seeking.
// - Bit 4 shows read/write command busy.
// - Bit 5 only in non-DMA execution.
// - Bit 6 gives transfer direction.
// - Bit 7 shows data register ready.
// - Reset idles, drive outputs low.
// - Strobes only act with chip select; a DMA grant also enables them.
// - Raise DMA request for byte transfer.
// - Transfer done ends the transfer.
// - Non-DMA interrupt for every data byte; raised only as the ready bit rises, so none for a byte queued behind another.
// - DMA bytes move without processor action.
// - Select pin high seek, low read/write.
// - Low current or step direction pin.
// - Fault reset or step pulse pin.
// - Head load command to drive.
// - Data strobe clears interrupt in execution.
// - DMA request drops when grant low.
// - Transfer done aborts running command.
`default_nettype none

package floppy_host_pkg;

   localparam int         DATA_W          = 8;
   localparam int         FIFO_DEPTH      = 32;
   localparam int         DRIVE_COUNT     = 4;
   localparam int         PIN_CTL_W       = 6;
   localparam int         ST_SEEK_LSB     = 0;
   localparam int         ST_BUSY_BIT     = 4;
   localparam int         ST_CPU_XFER_BIT = 5;
   localparam int         ST_DIR_BIT      = 6;
   localparam int         ST_READY_BIT    = 7;
   localparam logic [7:0] STATUS_RESET    = 8'h00;
   localparam logic [7:0] DATA_RESET      = 8'h00;
   localparam logic       SEL_STATUS      = 1'b0;
   localparam logic       SEL_DATA        = 1'b1;

   typedef enum logic [1:0] {
      ACC_IDLE,
      ACC_STATUS_RD,
      ACC_DATA_RD,
      ACC_DATA_WR
   } access_t;

endpackage

`default_nettype wire

//--- hw/floppy_ctrl_host_interface.sv
`default_nettype none

// ----------------------------------------------------------------
// Two-stage synchroniser
// ----------------------------------------------------------------
module pin_sync #(
   parameter int W = 1
) (
   input  wire logic         sys_clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] pin_out
);
   logic [W-1:0] meta_q;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q  <= '0;
         pin_out <= '0;
      end else begin
         meta_q  <= pin_in;
         pin_out <= meta_q;
      end
   end
endmodule

// ----------------------------------------------------------------
// Byte FIFO
// ----------------------------------------------------------------
module byte_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 32
) (
   input  wire logic         sys_clk,
   input  wire logic         rst_n,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic      [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [AW:0]   count_q;
   logic          push;
   logic          pop;

   assign in_ready  = (count_q != (AW+1)'(DEPTH));
   assign out_valid = (count_q != '0);
   assign out_data  = mem_q[rd_ptr_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end

   // Pointers wrap by hand so that a depth that is not a power of two still works.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
         end
         count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ----------------------------------------------------------------
// Host port of the controller
// ----------------------------------------------------------------
module floppy_ctrl_host_interface #(
   parameter int FIFO_DEPTH = floppy_host_pkg::FIFO_DEPTH
) (
   input  wire logic                                   sys_clk,
   input  wire logic                                   rst_n,
   input  wire logic                                   cs_n,
   input  wire logic                                   rd_n,
   input  wire logic                                   wr_n,
   input  wire logic                                   register_select,
   input  wire logic [floppy_host_pkg::DATA_W-1:0]     data_in,
   output logic      [floppy_host_pkg::DATA_W-1:0]     data_out,
   output logic                                        data_oe,
   output logic                                        host_irq,
   output logic                                        dma_request_out,
   input  wire logic                                   dma_grant_in_n,
   input  wire logic                                   transfer_done,
   input  wire logic [floppy_host_pkg::DRIVE_COUNT-1:0] seek_busy,
   input  wire logic                                   core_busy,
   input  wire logic                                   exec_active,
   input  wire logic                                   dma_mode,
   input  wire logic                                   core_accepts,
   input  wire logic                                   rx_valid,
   output logic                                        rx_ready,
   input  wire logic [floppy_host_pkg::DATA_W-1:0]     rx_data,
   output logic                                        tx_valid,
   input  wire logic                                   tx_ready,
   output logic      [floppy_host_pkg::DATA_W-1:0]     tx_data,
   output logic                                        abort_cmd,
   input  wire logic                                   seek_mode,
   input  wire logic                                   step_dir,
   input  wire logic                                   step_pulse,
   input  wire logic                                   low_current,
   input  wire logic                                   fault_reset,
   input  wire logic                                   head_load,
   output logic                                        access_or_positioning_select,
   output logic                                        write_current_or_step_sense,
   output logic                                        fault_clear_or_step_pulse,
   output logic                                        head_load_cmd
);
   import floppy_host_pkg::*;

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   logic              s_cs_n;
   logic              s_rd_n;
   logic              s_wr_n;
   logic              s_rs;
   logic              s_dma_grant_in_n;
   logic              s_tc;
   logic [DATA_W-1:0] s_data;

   pin_sync #(.W(PIN_CTL_W)) u_ctl_sync (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .pin_in  ({cs_n, rd_n, wr_n, register_select, dma_grant_in_n, transfer_done}),
      .pin_out ({s_cs_n, s_rd_n, s_wr_n, s_rs, s_dma_grant_in_n, s_tc})
   );

   pin_sync #(.W(DATA_W)) u_data_sync (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .pin_in  (data_in),
      .pin_out (s_data)
   );

   // ----------------------------------------------------------------
   // Access decode
   // ----------------------------------------------------------------
   access_t           access_q;
   access_t           access_d;
   logic              dev_sel;
   logic              dma_sel;
   logic              rd_only;
   logic              wr_only;
   logic              rd_end;
   logic              wr_end;
   logic              data_start;

   assign dev_sel = !s_cs_n;
   assign dma_sel = !s_dma_grant_in_n;
   assign rd_only = !s_rd_n && s_wr_n;
   assign wr_only = !s_wr_n && s_rd_n;
   assign rd_end  = s_rd_n;
   assign wr_end  = s_wr_n;

   // A DMA grant selects the data register on its own, so the DMA
   // controller needs neither chip select nor register select.
   always_comb begin
      access_d = access_q;
      case (access_q)
         ACC_IDLE: begin
            if (rd_only && (dma_sel || (dev_sel && s_rs == SEL_DATA))) begin
               access_d = ACC_DATA_RD;
            end else if (rd_only && dev_sel && s_rs == SEL_STATUS) begin
               access_d = ACC_STATUS_RD;
            end else if (wr_only && (dma_sel || (dev_sel && s_rs == SEL_DATA))) begin
               access_d = ACC_DATA_WR;
            end else begin
               access_d = ACC_IDLE;
            end
         end
         ACC_STATUS_RD, ACC_DATA_RD: begin
            if (rd_end) begin
               access_d = ACC_IDLE;
            end
         end
         ACC_DATA_WR: begin
            if (wr_end) begin
               access_d = ACC_IDLE;
            end
         end
         default: access_d = ACC_IDLE;
      endcase
   end

   assign data_start = (access_q == ACC_IDLE) &&
                       (access_d == ACC_DATA_RD || access_d == ACC_DATA_WR);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         access_q <= ACC_IDLE;
      end else begin
         access_q <= access_d;
      end
   end

   // ----------------------------------------------------------------
   // Read path: result and execution bytes queue toward the host
   // ----------------------------------------------------------------
   logic              head_valid;
   logic [DATA_W-1:0] head_byte;
   logic              pop_fire;

   // The byte leaves the stack only when the strobe ends, so a long
   // read strobe keeps showing the same byte.
   assign pop_fire = (access_q == ACC_DATA_RD) && rd_end && head_valid;

   byte_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .in_valid  (rx_valid),
      .in_ready  (rx_ready),
      .in_data   (rx_data),
      .out_valid (head_valid),
      .out_ready (pop_fire),
      .out_data  (head_byte)
   );

   // ----------------------------------------------------------------
   // Write path: command and execution bytes toward the core
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] wr_hold_q;
   logic [DATA_W-1:0] cmd_data_q;
   logic              tx_valid_q;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_hold_q <= DATA_RESET;
      end else if (access_q == ACC_DATA_WR && !s_wr_n) begin
         wr_hold_q <= s_data;
      end
   end

   // A write that arrives while the previous byte is still pending is
   // dropped; the host is expected to wait for the ready bit.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_data_q <= DATA_RESET;
         tx_valid_q <= 1'b0;
      end else if (access_q == ACC_DATA_WR && wr_end && !tx_valid_q) begin
         cmd_data_q <= wr_hold_q;
         tx_valid_q <= 1'b1;
      end else if (tx_ready) begin
         tx_valid_q <= 1'b0;
      end
   end

   assign tx_valid = tx_valid_q;
   assign tx_data  = cmd_data_q;

   // ----------------------------------------------------------------
   // Status register
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] status_q;
   logic [DATA_W-1:0] status_d;
   logic              ready_now;

   assign ready_now = head_valid || (core_accepts && !tx_valid_q && access_q != ACC_DATA_WR);

   always_comb begin
      status_d = STATUS_RESET;
      status_d[ST_SEEK_LSB +: DRIVE_COUNT] = seek_busy;
      status_d[ST_BUSY_BIT]     = core_busy;
      status_d[ST_CPU_XFER_BIT] = exec_active && !dma_mode;
      status_d[ST_DIR_BIT]      = head_valid;
      status_d[ST_READY_BIT]    = ready_now;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_q <= STATUS_RESET;
      end else begin
         status_q <= status_d;
      end
   end

   // ----------------------------------------------------------------
   // Data bus drive
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         data_out <= DATA_RESET;
         data_oe  <= 1'b0;
      end else begin
         data_oe  <= (access_q == ACC_STATUS_RD) || (access_q == ACC_DATA_RD);
         if (access_q == ACC_STATUS_RD) begin
            data_out <= status_q;
         end else if (access_q == ACC_DATA_RD) begin
            data_out <= head_byte;
         end
      end
   end

   // ----------------------------------------------------------------
   // DMA handshake, interrupt and abort
   // ----------------------------------------------------------------
   logic drq_q;
   logic irq_q;
   logic tc_prev_q;
   logic ready_prev_q;
   logic abort_q;
   logic byte_event;

   assign byte_event = ready_now && !ready_prev_q && exec_active;

   // The grant drop wins over a new request so that no byte is requested twice.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         drq_q <= 1'b0;
      end else if (dma_sel || s_tc) begin
         drq_q <= 1'b0;
      end else if (dma_mode && exec_active && ready_now && access_q == ACC_IDLE) begin
         drq_q <= 1'b1;
      end
   end

   // A new byte event in the same cycle as the clearing strobe still sets the flag.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_q <= 1'b0;
      end else if (byte_event && !dma_mode) begin
         irq_q <= 1'b1;
      end else if (data_start && dev_sel) begin
         irq_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tc_prev_q    <= 1'b0;
         ready_prev_q <= 1'b0;
         abort_q      <= 1'b0;
      end else begin
         tc_prev_q    <= s_tc;
         ready_prev_q <= ready_now;
         abort_q      <= s_tc && !tc_prev_q && core_busy;
      end
   end

   assign dma_request_out = drq_q;
   assign host_irq        = irq_q;
   assign abort_cmd       = abort_q;

   // ----------------------------------------------------------------
   // Drive outputs
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         access_or_positioning_select <= 1'b0;
         write_current_or_step_sense  <= 1'b0;
         fault_clear_or_step_pulse    <= 1'b0;
         head_load_cmd                <= 1'b0;
      end else begin
         access_or_positioning_select <= seek_mode;
         write_current_or_step_sense  <= seek_mode ? step_dir : low_current;
         fault_clear_or_step_pulse    <= seek_mode ? step_pulse : fault_reset;
         head_load_cmd                <= head_load;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   status_read_a : assert property (access_q == ACC_STATUS_RD |=> data_oe && data_out == $past(status_q))
      else $error("status read returned wrong byte");
   data_read_a : assert property (access_q == ACC_DATA_RD |=> data_oe && data_out == $past(head_byte))
      else $error("data read returned wrong byte");
   data_write_a : assert property ((access_q == ACC_DATA_WR && wr_end && !tx_valid_q) |=> tx_valid && tx_data == $past(wr_hold_q))
      else $error("data write not captured");
   cs_gate_a : assert property ((s_cs_n && s_dma_grant_in_n && access_q == ACC_IDLE) |=> access_q == ACC_IDLE)
      else $error("strobe accepted without select");
   illegal_hold_a : assert property ((access_q == ACC_IDLE && !s_rd_n && !s_wr_n) |=> access_q == ACC_IDLE && !$rose(tx_valid_q) && $stable(cmd_data_q))
      else $error("illegal strobe caused an access");
   seek_bits_a : assert property (##1 status_q[ST_SEEK_LSB +: DRIVE_COUNT] == $past(seek_busy))
      else $error("seek busy bits wrong");
   cpu_flag_a : assert property (status_q[ST_CPU_XFER_BIT] |-> $past(exec_active && !dma_mode))
      else $error("cpu transfer flag outside non-DMA execution");
   dir_ready_a : assert property (status_q[ST_DIR_BIT] |-> status_q[ST_READY_BIT])
      else $error("direction out without ready");
   drq_drop_a : assert property (dma_sel |=> !dma_request_out)
      else $error("DMA request held during grant");
   irq_mode_a : assert property ($rose(host_irq) |-> $past(!dma_mode && exec_active))
      else $error("interrupt raised outside non-DMA execution");
   abort_a : assert property ((s_tc && !tc_prev_q && core_busy) |=> abort_cmd ##1 !abort_cmd)
      else $error("transfer done did not abort");
endmodule

`default_nettype wire

//--- dv/dma_partner.sv
`default_nettype none

// ----------------------------------------------------------------
// External DMA controller
// ----------------------------------------------------------------
// Answers each request after lat falling edges, so one model covers
// both a prompt and a slow controller.
module dma_partner (
   input  wire logic       sys_clk,
   input  wire logic       dma_request_out,
   input  wire logic [7:0] data_out,
   input  wire logic       end_req,
   input  wire logic [7:0] lat,
   output logic            dma_grant_in_n,
   output logic            dma_rd_n,
   output logic            transfer_done,
   output logic [7:0]      got,
   output logic [7:0]      got_cnt
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      dma_grant_in_n = 1'b1;
      dma_rd_n = 1'b1;
      transfer_done = 1'b0;
      got = 8'h00;
      got_cnt = 8'h00;
      forever begin
         @(negedge sys_clk);
         if (end_req) begin
            transfer_done = 1'b1;
            repeat (4) @(negedge sys_clk);
            transfer_done = 1'b0;
         end else if (dma_request_out === 1'b1) begin
            repeat (lat) @(negedge sys_clk);
            dma_grant_in_n = 1'b0;
            dma_rd_n = 1'b0;
            repeat (6) @(negedge sys_clk);
            got = data_out;
            got_cnt = got_cnt + 8'h01;
            dma_grant_in_n = 1'b1;
            dma_rd_n = 1'b1;
            repeat (4) @(negedge sys_clk);
         end
      end
   end
endmodule

`default_nettype wire

//--- dv/test_floppy_ctrl_host_interface.sv
`default_nettype none

module test_floppy_ctrl_host_interface;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DEPTH = 4;

   logic sys_clk, rst_n, cs_n, tb_rd_n, wr_n, register_select, core_busy, exec_active, dma_mode;
   logic core_accepts, rx_valid, tx_ready, seek_mode, step_dir, step_pulse, low_current, fault_reset;
   logic head_load, end_req, data_oe, host_irq, dma_request_out, rx_ready, tx_valid, abort_cmd;
   logic dma_grant_in_n, dma_rd_n, transfer_done, access_or_positioning_select;
   logic write_current_or_step_sense, fault_clear_or_step_pulse, head_load_cmd, oe;
   logic [7:0] data_in, rx_data, data_out, tx_data, q, b, got, got_cnt, lat, k;
   logic [7:0] exp_q [DEPTH];
   logic [3:0] seek_busy;
   logic [31:0] seed;
   int error_cnt, samples_checked, i, j;
   wire logic rd_n;
   assign rd_n = tb_rd_n & dma_rd_n;

   floppy_ctrl_host_interface #(.FIFO_DEPTH(DEPTH)) i_floppy_ctrl_host_interface (
      .sys_clk, .rst_n, .cs_n, .rd_n, .wr_n, .register_select, .data_in, .data_out, .data_oe,
      .host_irq, .dma_request_out, .dma_grant_in_n, .transfer_done, .seek_busy, .core_busy,
      .exec_active, .dma_mode, .core_accepts, .rx_valid, .rx_ready, .rx_data, .tx_valid, .tx_ready,
      .tx_data, .abort_cmd, .seek_mode, .step_dir, .step_pulse, .low_current, .fault_reset,
      .head_load, .access_or_positioning_select, .write_current_or_step_sense,
      .fault_clear_or_step_pulse, .head_load_cmd);

   dma_partner i_dma_partner (
      .sys_clk, .dma_request_out, .data_out, .end_req, .lat, .dma_grant_in_n, .dma_rd_n,
      .transfer_done, .got, .got_cnt);

   always #2 sys_clk = ~sys_clk;

   // ----------------------------------------------------------------
   // Expectations and bus cycles
   // ----------------------------------------------------------------
   function automatic logic [7:0] exp_st(input logic [3:0] sk, input logic bz, input logic ex,
                                         input logic dm, input logic ne, input logic rdy);
      return {rdy, ne, ex & ~dm, bz, sk};
   endfunction

   function automatic logic [7:0] exp_pins();
      return {4'h0, seek_mode, seek_mode ? step_dir : low_current, seek_mode ? step_pulse : fault_reset,
              head_load};
   endfunction

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Strobes are held six cycles so the two-stage synchronisers see them well settled.
   task automatic acc(input logic cs, input logic rs, input logic rd, input logic wr, input logic [7:0] d);
      @(negedge sys_clk);
      cs_n = cs;
      register_select = rs;
      tb_rd_n = rd;
      wr_n = wr;
      data_in = d;
      repeat (6) @(negedge sys_clk);
      q = data_out;
      oe = data_oe;
      cs_n = 1'b1;
      tb_rd_n = 1'b1;
      wr_n = 1'b1;
      repeat (4) @(negedge sys_clk);
      data_in = ~d;
   endtask

   task automatic push(input logic [7:0] v);
      @(negedge sys_clk);
      rx_valid = 1'b1;
      rx_data = v;
      @(negedge sys_clk);
      rx_valid = 1'b0;
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      seed = 32'h4cf6;
      {sys_clk, rst_n, cs_n, tb_rd_n, wr_n, register_select, core_busy, exec_active} = 8'h3c;
      {dma_mode, core_accepts, rx_valid, tx_ready, seek_mode, step_dir, step_pulse, low_current} = 8'h00;
      {fault_reset, head_load, end_req} = 3'h0;
      {data_in, rx_data, seek_busy, lat} = 28'h0;
      error_cnt = 0;
      samples_checked = 0;
      repeat (3) @(negedge sys_clk);
      chk("drive_pins", 8'h00, {4'h0, access_or_positioning_select, write_current_or_step_sense,
          fault_clear_or_step_pulse, head_load_cmd});
      chk("irq_drq_ready", 8'h01, {host_irq, dma_request_out, rx_ready});
      rst_n = 1'b1;
      repeat (2) @(negedge sys_clk);
      for (i = 0; i < 8; i++) begin
         {seek_busy, core_busy, exec_active, seek_mode, step_dir, step_pulse, low_current,
          fault_reset, head_load} = 12'($random(seed));
         acc(1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
         chk("status", exp_st(seek_busy, core_busy, exec_active, 1'b0, 1'b0, 1'b0), q);
         chk("data_oe", 8'h01, {7'h0, oe});
         chk("drive_pins", exp_pins(), {4'h0, access_or_positioning_select, write_current_or_step_sense,
             fault_clear_or_step_pulse, head_load_cmd});
      end
      exec_active = 1'b1;
      b = 8'($random(seed));
      push(b);
      repeat (4) @(negedge sys_clk);
      chk("irq", 8'h01, {7'h0, host_irq});
      acc(1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
      chk("status", exp_st(seek_busy, core_busy, 1'b1, 1'b0, 1'b1, 1'b1), q);
      acc(1'b0, 1'b1, 1'b0, 1'b1, 8'h00);
      chk("data", b, q);
      chk("irq", 8'h00, {7'h0, host_irq});
      // Fill the buffer with the core side stalled, then try a deselected read, both strobes together and a status write.
      exec_active = 1'b0;
      for (i = 0; i < DEPTH; i++) begin
         exp_q[i] = 8'($random(seed));
         push(exp_q[i]);
      end
      chk("rx_ready", 8'h00, {7'h0, rx_ready});
      acc(1'b1, 1'b1, 1'b0, 1'b1, 8'h00);
      chk("data_oe", 8'h00, {7'h0, oe});
      acc(1'b0, 1'b1, 1'b0, 1'b0, 8'h5a);
      chk("data_oe", 8'h00, {7'h0, oe});
      acc(1'b0, 1'b0, 1'b1, 1'b0, 8'h5a);
      chk("tx_valid", 8'h00, {7'h0, tx_valid});
      for (i = 0; i < DEPTH; i++) begin
         acc(1'b0, 1'b1, 1'b0, 1'b1, 8'h00);
         chk("data", exp_q[i], q);
      end
      core_accepts = 1'b1;
      acc(1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
      chk("status", exp_st(seek_busy, core_busy, 1'b0, 1'b0, 1'b0, 1'b1), q);
      b = 8'($random(seed));
      acc(1'b0, 1'b1, 1'b1, 1'b0, b);
      chk("tx_data", b, tx_valid ? tx_data : ~b);
      acc(1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
      chk("status", exp_st(seek_busy, core_busy, 1'b0, 1'b0, 1'b0, 1'b0), q);
      tx_ready = 1'b1;
      core_accepts = 1'b0;
      repeat (2) @(negedge sys_clk);
      chk("tx_valid", 8'h00, {7'h0, tx_valid});
      // DMA transfers with a prompt and then a slow controller, then a terminal count abort.
      dma_mode = 1'b1;
      exec_active = 1'b1;
      for (j = 0; j < 2; j++) begin
         lat = 8'(j * 3);
         b = 8'($random(seed));
         push(b);
         for (i = 0; i < 80 && got_cnt == 8'(j); i++)
            @(negedge sys_clk);
         chk("dma_byte", b, got);
         chk("dma_request", 8'h00, {7'h0, dma_request_out});
         chk("dma_irq", 8'h00, {7'h0, host_irq});
      end
      core_busy = 1'b1;
      end_req = 1'b1;
      // The partner may still be finishing its last grant, so hold the request until it answers.
      for (i = 0; i < 40 && transfer_done !== 1'b1; i++)
         @(negedge sys_clk);
      end_req = 1'b0;
      k = 8'h00;
      for (i = 0; i < 14; i++) begin
         @(negedge sys_clk);
         k = k + 8'(abort_cmd === 1'b1);
      end
      chk("abort_pulses", 8'h01, k);
      tally_and_finish;
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      tally_and_finish;
   end
endmodule

`default_nettype wire
